// *** hw/adc_postfilter.sv ***
// adc_postfilter: two-channel decimation, dc removal, input select
// and sample-phase shift, with an avalon-mm register slave
// assumes: clk_i is the modulator clock, one bit per channel per edge;
// modulator and test bits arrive from pins, asynchronous to clk_i
//
// Function
// RULE1: sinc3 decimator for ratios up to 1024
// RULE2: above 1024, sinc3 at 1024 then sinc1
// RULE3: cutoff code zero bypasses dc removal everywhere
// RULE4: per-channel bit bypasses dc removal
// RULE5: code k gives coefficient two to -(k+1)
// RULE6: recursive high-pass, shift arithmetic, per sample
// RULE7: host ignores samples while high-pass settles
// RULE8: high-pass runs at output sample rate
// RULE9: 2-bit field selects normal or test input
// RULE10: one code each, fourth code reserved
// RULE11: one shared test signal for all channels
// RULE12: 10-bit signed phase field per channel
// RULE13: phase counts modulator cycles of window shift
// RULE14: each result uses exactly ratio modulator samples
// RULE15: equal phases give aligned windows
// RULE16: phase moves window edges, keeps its length
// RULE17: clip phase to half ratio, max 511
`timescale 1ns/1ns
`default_nettype none
module adc_postfilter (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    output logic [31:0] readdata_o,
    output logic waitrequest_o,
    input wire logic [1:0] mod_bits_i,
    input wire logic test_bit_i,
    output logic [23:0] sample0_o,
    output logic [23:0] sample1_o,
    output logic [1:0] sample_valid_o
);
    localparam int NCH = postfilter_pkg::NCH;
    localparam int DW = postfilter_pkg::DATA_W;
    localparam int EW = postfilter_pkg::EST_W;
    localparam int RW = postfilter_pkg::REF_W;
    localparam int PL = postfilter_pkg::PHASE_LSB;
    localparam int PW = postfilter_pkg::PHASE_W;
    localparam int IL = postfilter_pkg::INSEL_LSB;
    localparam int IW = postfilter_pkg::INSEL_W;
    localparam int CW = postfilter_pkg::CFG_W;
    localparam int HW = postfilter_pkg::HP_W;

    // ==========================================================
    // pin synchronisers
    // pins are not timed against clk_i, so two flops before any use
    logic [1:0] mod_meta_reg, mod_sync_reg;
    logic test_meta_reg, test_sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mod_meta_reg <= '0;
            mod_sync_reg <= '0;
            test_meta_reg <= 1'b0;
            test_sync_reg <= 1'b0;
        end else begin
            mod_meta_reg <= mod_bits_i;
            mod_sync_reg <= mod_meta_reg;
            test_meta_reg <= test_bit_i;
            test_sync_reg <= test_meta_reg;
        end
    end

    // ==========================================================
    // registers
    logic [3:0] osr_reg;
    logic [3:0] hp_sel_reg;
    logic [12:0] cfg_reg [NCH];
    logic [23:0] data_reg [NCH];
    logic [1:0] ready_reg;
    logic [1:0] valid_reg;
    logic wait_reg;
    logic [31:0] rdata_reg;

    // ==========================================================
    // bus decode
    // one wait cycle per access: the answer edge is the second edge
    wire logic req = read_i | write_i;
    wire logic done = req & ~wait_reg;
    wire logic wr = done & write_i;
    wire logic rd = done & read_i;
    // one address compare per register, shared by writes and read mux
    wire logic hit_ratio = address_i == postfilter_pkg::OFS_OSR;
    wire logic hit_hp = address_i == postfilter_pkg::OFS_HP;
    wire logic hit_cfg0 = address_i == postfilter_pkg::OFS_CFG0;
    wire logic hit_cfg1 = address_i == postfilter_pkg::OFS_CFG1;
    wire logic hit_data0 = address_i == postfilter_pkg::OFS_DATA0;
    wire logic hit_data1 = address_i == postfilter_pkg::OFS_DATA1;
    wire logic hit_status = address_i == postfilter_pkg::OFS_STATUS;

    wire logic wr_osr = wr & hit_ratio;
    wire logic wr_hp = wr & hit_hp;
    wire logic wr_cfg0 = wr & hit_cfg0;
    wire logic wr_cfg1 = wr & hit_cfg1;
    wire logic rd_data0 = rd & hit_data0;
    wire logic rd_data1 = rd & hit_data1;
    wire logic [1:0] rd_data = {rd_data1, rd_data0};
    wire logic [1:0] wr_cfg = {wr_cfg1, wr_cfg0};

    // ratio codes above the table are held at the largest ratio
    wire logic [3:0] osr_wr_val =
        (writedata_i[3:0] > postfilter_pkg::OSR_CODE_MAX) ?
        postfilter_pkg::OSR_CODE_MAX : writedata_i[3:0];

    // ==========================================================
    // read words, upper bits zero
    wire logic [31:0] word_ratio = 32'(osr_reg);
    wire logic [31:0] word_hp = 32'(hp_sel_reg);
    wire logic [31:0] word_cfg0 = 32'(cfg_reg[0]);
    wire logic [31:0] word_cfg1 = 32'(cfg_reg[1]);
    wire logic [31:0] word_data0 = 32'(data_reg[0]);
    wire logic [31:0] word_data1 = 32'(data_reg[1]);
    wire logic [31:0] word_status = 32'(ready_reg);

    wire logic [31:0] rdata_next =
        hit_ratio ? word_ratio :
        hit_hp ? word_hp :
        hit_cfg0 ? word_cfg0 :
        hit_cfg1 ? word_cfg1 :
        hit_data0 ? word_data0 :
        hit_data1 ? word_data1 :
        hit_status ? word_status :
        32'h0;

    // ==========================================================
    // handshake: waitrequest idles high, so no access is zero-wait
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wait_reg <= 1'b1;
            rdata_reg <= '0;
        end else begin
            wait_reg <= ~(req & wait_reg);
            rdata_reg <= rdata_next;
        end
    end

    // ==========================================================
    // ratio and cutoff settings
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osr_reg <= postfilter_pkg::OSR_RESET;
            hp_sel_reg <= postfilter_pkg::HP_RESET;
        end else begin
            if (wr_osr) begin
                osr_reg <= osr_wr_val;
            end
            if (wr_hp) begin
                hp_sel_reg <= writedata_i[HW-1:0];
            end
        end
    end

    assign readdata_o = rdata_reg;
    assign waitrequest_o = wait_reg;

    // ==========================================================
    // ratio split and shared window reference
    // above 1024 the sinc3 stays at 1024 and sinc1 does the rest
    wire logic split = osr_reg > postfilter_pkg::SINC3_FULL_CODE;
    wire logic [3:0] log_all = osr_reg + postfilter_pkg::LOG_OSR_MIN;
    wire logic [3:0] log3 =
        split ? postfilter_pkg::LOG_SINC3_MAX : log_all; // see RULE2
    wire logic [3:0] log1 =
        split ? (osr_reg - postfilter_pkg::SINC3_FULL_CODE) : 4'h0;
    wire logic [10:0] osr3 = 11'h1 << log3;
    wire logic [10:0] osr3_m1 = osr3 - 11'h1;
    wire logic signed [10:0] half = $signed(osr3 >> 1);
    wire logic signed [10:0] ph_hi = half - 11'sh1;
    wire logic signed [10:0] ph_lo = -half;

    // zero-phase reference window runs over 0 .. sinc3 ratio-1 (0 .. 1023 above 1024)
    logic [RW-1:0] ref_reg;
    wire logic ref_wrap = ref_reg >= osr3_m1[RW-1:0];
    wire logic [RW-1:0] ref_next =
        ref_wrap ? '0 : ref_reg + RW'(1); // see RULE14

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ref_reg <= '0;
        end else begin
            ref_reg <= ref_next;
        end
    end

    // ==========================================================
    // dc removal control shared by both channels
    wire logic hp_global = hp_sel_reg != 4'h0; // see RULE3
    wire logic [4:0] hp_shift = 5'(hp_sel_reg) + 5'h1; // see RULE5

    // ==========================================================
    // per-channel datapath
    logic [1:0] dec_valid;
    logic [23:0] dec_data [NCH];
    logic [1:0] ready_next;

    genvar c;
    generate
        for (c = 0; c < NCH; c = c + 1) begin : g_ch
            wire logic [IW-1:0] insel = cfg_reg[c][IL +: IW];
            wire logic bypass = cfg_reg[c][postfilter_pkg::BYPASS_BIT];
            wire logic [PW-1:0] ph_field = cfg_reg[c][PL +: PW];
            wire logic signed [10:0] ph_raw =
                11'($signed(ph_field)); // see RULE12 see RULE13

            // one spare bit so the clip compares never overflow
            // see RULE17
            wire logic signed [10:0] ph_clip =
                (ph_raw > ph_hi) ? ph_hi :
                (ph_raw < ph_lo) ? ph_lo : ph_raw;
            // window end sits ph_clip cycles after the reference end
            wire logic [10:0] pos = (osr3_m1 + ph_clip) & osr3_m1;
            wire logic dump =
                ref_reg == pos[RW-1:0]; // see RULE15 see RULE16

            // reserved select code falls through to the normal input
            // see RULE9 see RULE10 see RULE11
            wire logic chan_bit =
                (insel == postfilter_pkg::INSEL_TEST_POS) ? test_sync_reg :
                (insel == postfilter_pkg::INSEL_TEST_NEG) ? ~test_sync_reg :
                mod_sync_reg[c];

            chan_decim u_decim (
                .clk_i(clk_i),
                .rst_i(rst_i),
                .bit_i(chan_bit),
                .dump_i(dump),
                .log3_i(log3),
                .log1_i(log1),
                .data_o(dec_data[c]),
                .valid_o(dec_valid[c])
            );

            // first-order high-pass: y = x - est, est += a * y
            // 16 fraction bits let the smallest step still move est
            logic signed [EW-1:0] est_reg;
            wire logic hp_on = hp_global && !bypass; // see RULE4
            wire logic signed [EW-1:0] xw =
                EW'($signed(dec_data[c])) <<< postfilter_pkg::HP_FRAC;
            wire logic signed [EW-1:0] diff = xw - est_reg; // see RULE6
            wire logic signed [EW-1:0] est_next =
                est_reg + (diff >>> hp_shift);
            wire logic signed [EW-1:0] y_full =
                diff >>> postfilter_pkg::HP_FRAC;
            wire logic signed [EW-1:0] y_top = y_full >>> (DW - 1);
            wire logic y_over = !y_full[EW-1] && (y_top != '0);
            wire logic y_under = y_full[EW-1] && (y_top != '1);
            wire logic [23:0] y_sat =
                y_over ? 24'h7fffff :
                y_under ? 24'h800000 : y_full[DW-1:0];
            wire logic [23:0] y = hp_on ? y_sat : dec_data[c];

            always_ff @(posedge clk_i) begin
                if (rst_i) begin
                    est_reg <= '0;
                    data_reg[c] <= '0;
                    cfg_reg[c] <= postfilter_pkg::CFG_RESET;
                end else begin
                    if (wr_cfg[c]) begin
                        cfg_reg[c] <= writedata_i[CW-1:0];
                    end
                    // estimate restarts from zero whenever the stage is off
                    if (!hp_on) begin
                        est_reg <= '0;
                    end else if (dec_valid[c]) begin
                        est_reg <= est_next; // see RULE8 see RULE6
                    end
                    if (dec_valid[c]) begin
                        data_reg[c] <= y;
                    end
                end
            end

            // new-sample flag: a fresh sample beats the read that clears
            assign ready_next[c] = dec_valid[c] |
                                   (ready_reg[c] & ~rd_data[c]);
        end
    endgenerate

    // ==========================================================
    // result strobes
    // valid leaves a flop at the same edge that loads the data word
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ready_reg <= '0;
            valid_reg <= '0;
        end else begin
            ready_reg <= ready_next;
            valid_reg <= dec_valid;
        end
    end

    assign sample0_o = data_reg[0];
    assign sample1_o = data_reg[1];
    assign sample_valid_o = valid_reg;
endmodule
`default_nettype wire

// *** hw/chan_decim.sv ***
// chan_decim: one channel of sinc3 plus optional sinc1 decimation
// assumes: one modulator bit per clk_i, window end given by dump_i
`timescale 1ns/1ns
`default_nettype none
module chan_decim (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic bit_i,
    input wire logic dump_i,
    input wire logic [3:0] log3_i,
    input wire logic [3:0] log1_i,
    output logic [23:0] data_o,
    output logic valid_o
);
    localparam int W3 = postfilter_pkg::SINC3_W;
    localparam int WS = postfilter_pkg::SUM_W;

    // ==========================================================
    // sinc3: three integrators at the modulator rate
    logic signed [W3-1:0] i1_reg, i2_reg, i3_reg;
    logic signed [W3-1:0] d1_reg, d2_reg, d3_reg;
    logic signed [W3-1:0] s3_reg;
    logic v3_reg;
    wire logic signed [W3-1:0] x = bit_i ? W3'(1) : -W3'(1);
    // wrap-around in the integrators cancels in the combs
    wire logic signed [W3-1:0] c1 = i3_reg - d1_reg;
    wire logic signed [W3-1:0] c2 = c1 - d2_reg;
    wire logic signed [W3-1:0] c3 = c2 - d3_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            i1_reg <= '0;
            i2_reg <= '0;
            i3_reg <= '0;
            d1_reg <= '0;
            d2_reg <= '0;
            d3_reg <= '0;
            s3_reg <= '0;
            v3_reg <= 1'b0;
        end else begin
            i1_reg <= i1_reg + x;
            i2_reg <= i2_reg + i1_reg;
            i3_reg <= i3_reg + i2_reg;
            v3_reg <= dump_i;
            if (dump_i) begin // see RULE1 see RULE14
                d1_reg <= i3_reg;
                d2_reg <= c1;
                d3_reg <= c2;
                s3_reg <= c3;
            end
        end
    end

    // ==========================================================
    // sinc1: sums 2 to 16 sinc3 results for the long ratios
    logic signed [WS-1:0] acc_reg;
    logic [3:0] cnt_reg;
    wire logic [4:0] n1 = 5'h1 << log1_i;
    wire logic [3:0] last1 = 4'(n1 - 5'h1);
    wire logic signed [WS-1:0] total = acc_reg + WS'(s3_reg);
    // >= so a ratio cut mid-count cannot skip past the end and stall
    wire logic end1 = v3_reg && (cnt_reg >= last1); // see RULE2

    // scale so that full scale lands on 24 bits
    wire logic [6:0] gain_log = 7'(log3_i) * 7'h3 + 7'(log1_i);
    wire logic [6:0] sh = gain_log - postfilter_pkg::NORM_BIAS;
    wire logic [6:0] nsh = -sh;
    wire logic signed [WS-1:0] scaled = sh[6] ? (total <<< nsh)
                                             : (total >>> sh);
    wire logic signed [WS-1:0] top = scaled >>> (postfilter_pkg::DATA_W - 1);
    wire logic over = !scaled[WS-1] && (top != '0);
    wire logic under = scaled[WS-1] && (top != '1);
    wire logic [23:0] sat = over ? 24'h7fffff :
                            under ? 24'h800000 : scaled[23:0];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc_reg <= '0;
            cnt_reg <= '0;
            data_o <= '0;
            valid_o <= 1'b0;
        end else begin
            valid_o <= end1;
            if (end1) begin
                acc_reg <= '0;
                cnt_reg <= '0;
                data_o <= sat;
            end else if (v3_reg) begin
                acc_reg <= total;
                cnt_reg <= cnt_reg + 4'h1;
            end
        end
    end
endmodule
`default_nettype wire

// *** hw/postfilter_pkg.sv ***
// postfilter_pkg: register map, field layout and filter constants
// assumes: shared by adc_postfilter and chan_decim, nothing imported
package postfilter_pkg;
    // ==========================================================
    // register map, byte addresses on the avalon slave
    localparam logic [4:0] OFS_OSR = 5'h00;
    localparam logic [4:0] OFS_HP = 5'h04;
    localparam logic [4:0] OFS_CFG0 = 5'h08;
    localparam logic [4:0] OFS_CFG1 = 5'h0c;
    localparam logic [4:0] OFS_DATA0 = 5'h10;
    localparam logic [4:0] OFS_DATA1 = 5'h14;
    localparam logic [4:0] OFS_STATUS = 5'h18;
    localparam int ADDR_W = 5;
    localparam int BUS_W = 32;

    // ==========================================================
    // channel_config_register layout, cutoff field width and reset
    localparam int PHASE_LSB = 0;
    localparam int PHASE_W = 10;
    localparam int INSEL_LSB = 10;
    localparam int INSEL_W = 2;
    localparam int BYPASS_BIT = 12;
    localparam int CFG_W = 13;
    localparam logic [12:0] CFG_RESET = 13'h0000;
    localparam int HP_W = 4;
    localparam logic [3:0] HP_RESET = 4'h0;

    // ==========================================================
    // oversample_ratio code: ratio = 2 ** (code + LOG_OSR_MIN)
    localparam int OSR_W = 4;
    localparam logic [3:0] OSR_RESET = 4'h4;
    localparam logic [3:0] OSR_CODE_MAX = 4'h8;
    localparam logic [3:0] LOG_OSR_MIN = 4'h6;
    localparam logic [3:0] LOG_SINC3_MAX = 4'ha;
    localparam logic [3:0] SINC3_FULL_CODE = 4'h4;

    // ==========================================================
    // input select codes
    typedef enum logic [1:0] {
        INSEL_NORMAL = 2'h0,
        INSEL_TEST_POS = 2'h1,
        INSEL_TEST_NEG = 2'h2,
        INSEL_RESERVED = 2'h3
    } insel_t;

    // ==========================================================
    // datapath widths
    localparam int NCH = 2;
    localparam int DATA_W = 24;
    localparam int SINC3_W = 32;
    localparam int SUM_W = 36;
    localparam int HP_FRAC = 16;
    localparam int EST_W = 40;
    localparam int REF_W = 10;
    localparam logic [6:0] NORM_BIAS = 7'h17;
endpackage

// *** verification/modulator_model.sv ***
// modulator_model: bit streams of both modulators and the test source
// assumes: levels set by the bench; bits change just after clk_i rises
`timescale 1ns/1ns
`default_nettype none
module modulator_model (
    input wire logic clk_i,
    input wire logic [1:0] level_i,
    input wire logic test_level_i,
    input wire logic noisy_i,
    output logic [1:0] mod_bits_o = 2'h0,
    output logic test_bit_o = 1'b0
);
    // a held level is full scale; noise is for timing-only tests
    always @(posedge clk_i) begin
        mod_bits_o <= noisy_i ? 2'($urandom) : level_i;
        test_bit_o <= test_level_i;
    end
endmodule
`default_nettype wire

// *** verification/postfilter_checker_properties.sv ***
// postfilter_checker: bus and sample-stream properties
// assumes: bound to adc_postfilter, sees its ports only
`timescale 1ns/1ns
`default_nettype none
module postfilter_checker (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [4:0] address_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic [31:0] writedata_i,
    input wire logic [31:0] readdata_o,
    input wire logic waitrequest_o,
    input wire logic [23:0] sample0_o,
    input wire logic [23:0] sample1_o,
    input wire logic [1:0] sample_valid_o
);
    // ======
    // shadow registers, cycles since each pulse
    logic [3:0] osr_reg, hp_reg;
    logic [9:0] ph0_reg, ph1_reg;
    logic [1:0] q_reg;
    logic [15:0] gap0_reg, gap1_reg;
    wire wr_ok = write_i && !waitrequest_o;
    wire rd_ok = read_i && !waitrequest_o;
    wire [15:0] ratio = 16'h1 << (osr_reg + 4'h6);
    wire same_ph = ph0_reg == ph1_reg;
    wire [3:0] osr_in = writedata_i[3:0] > 4'h8 ? 4'h8 : writedata_i[3:0];
    always_ff @(posedge clk_i) begin
        gap0_reg <= sample_valid_o[0] ? 16'h1 : gap0_reg + 16'h1;
        gap1_reg <= sample_valid_o[1] ? 16'h1 : gap1_reg + 16'h1;
    end
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            osr_reg <= 4'h4;
            hp_reg <= 4'h0;
            ph0_reg <= 10'h0;
            ph1_reg <= 10'h0;
            q_reg <= 2'h0;
        end else begin
            // a write to ratio or phase disturbs the running window
            if (wr_ok && address_i != 5'h04) q_reg <= 2'h0;
            else if (sample_valid_o[0] && q_reg != 2'h3) q_reg <= q_reg + 2'h1;
            if (wr_ok && address_i == 5'h00) osr_reg <= osr_in;
            if (wr_ok && address_i == 5'h04) hp_reg <= writedata_i[3:0];
            if (wr_ok && address_i == 5'h08) ph0_reg <= writedata_i[9:0];
            if (wr_ok && address_i == 5'h0c) ph1_reg <= writedata_i[9:0];
        end
    end
    // ======
    // properties
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    one_wait_state_a: assert property ((read_i || write_i) && waitrequest_o
        |=> !waitrequest_o) else $error("request not answered");
    wait_low_once_a: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("waitrequest low too long");
    unmapped_zero_a: assert property (rd_ok && address_i == 5'h1c
        |-> readdata_o == 32'h0) else $error("unmapped read not zero");
    ratio_readback_a: assert property (rd_ok && address_i == 5'h00
        |-> readdata_o == {28'h0, osr_reg}) else $error("bad ratio read");
    cutoff_readback_a: assert property (rd_ok && address_i == 5'h04
        |-> readdata_o == {28'h0, hp_reg}) else $error("bad cutoff read");
    data_readback_a: assert property (rd_ok && address_i == 5'h14
        && !sample_valid_o[1] |-> readdata_o == {8'h0, sample1_o})
        else $error("data read differs from sample");
    sample_hold_a: assert property (!sample_valid_o[0]
        |-> $stable(sample0_o)) else $error("sample moved without pulse");
    window_len0_a: assert property (sample_valid_o[0] && q_reg == 2'h3
        |-> gap0_reg == ratio) else $error("ch0 period wrong");
    window_len1_a: assert property (sample_valid_o[1] && q_reg == 2'h3
        |-> gap1_reg == ratio) else $error("ch1 period wrong");
    windows_aligned_a: assert property (sample_valid_o[0] && same_ph
        && q_reg == 2'h3 |-> sample_valid_o[1]) else $error("not aligned");
    cover property (sample_valid_o[1] && !same_ph && q_reg == 2'h3);
    cover property (rd_ok && address_i == 5'h1c);
    cover property (sample_valid_o[0] && q_reg == 2'h3 && ratio == 16'h0800);
endmodule
bind adc_postfilter postfilter_checker chk (.clk_i, .rst_i, .address_i,
    .read_i, .write_i, .writedata_i, .readdata_o, .waitrequest_o,
    .sample0_o, .sample1_o, .sample_valid_o);
`default_nettype wire

// *** verification/test_adc_postfilter.sv ***
// test_adc_postfilter: self-checking bench for adc_postfilter
// assumes: checker bound, modulator_model feeds the bit pins
`timescale 1ns/1ns
`default_nettype none
module test_adc_postfilter;
    logic clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
    logic [4:0] address_i = 5'h00;
    logic [31:0] writedata_i = 32'h0, readdata_o;
    logic waitrequest_o, test_bit_i, test_lvl = 1'b1, noisy = 1'b1;
    logic [1:0] mod_bits_i, sample_valid_o, lvl = 2'h2;
    logic [23:0] sample0_o, sample1_o;
    logic [31:0] exp_q[$], tol_q[$];
    logic [9:0] ph;
    logic [9:0] phs[5] = '{10'h000, 10'h005, 10'h3f9, 10'h064, 10'h39c};
    logic [1:0] s0[4] = '{2'h0, 2'h1, 2'h3, 2'h1};
    logic [1:0] s1[4] = '{2'h0, 2'h2, 2'h3, 2'h1};
    int mismatches = 0, checks_done = 0, cyc = 0, t0 = 0, t1 = 0, p0 = 0;
    adc_postfilter dut (.clk_i, .rst_i, .address_i, .read_i, .write_i,
        .writedata_i, .readdata_o, .waitrequest_o, .mod_bits_i, .test_bit_i,
        .sample0_o, .sample1_o, .sample_valid_o);
    modulator_model src (.clk_i, .level_i(lvl), .test_level_i(test_lvl),
        .noisy_i(noisy), .mod_bits_o(mod_bits_i), .test_bit_o(test_bit_i));
    initial begin
        forever #5 clk_i = ~clk_i;
    end
    // ======
    // helpers
    function automatic bit near(logic [31:0] g, logic [31:0] w,
        logic [31:0] tol);
        logic signed [23:0] d;
        d = g[23:0] - w[23:0];
        if (tol == 32'h0) return g === w;
        return g[31:24] === w[31:24] && (d < 0 ? -d : d) <= tol[23:0];
    endfunction
    function automatic logic [31:0] full(logic b);
        return b ? 32'h007fffff : 32'h00800000;
    endfunction
    function automatic logic pick(logic [1:0] sel, logic m);
        return sel == 2'h1 ? test_lvl : (sel == 2'h2 ? !test_lvl : m);
    endfunction
    function automatic int shift64(logic [9:0] v);
        int p;
        p = $signed(v);
        p = p > 31 ? 31 : (p < -32 ? -32 : p);
        return (p + 64) % 64;
    endfunction
    task automatic check(int got, int want);
        checks_done++;
        if (got != want) begin
            mismatches++;
            $display("MISMATCH t=%0t got %0d want %0d", $time, got, want);
        end
    endtask
    // holds the request until waitrequest is sampled low
    task automatic bus(bit wr, logic [4:0] a, logic [31:0] d,
        logic [31:0] tol);
        @(posedge clk_i);
        address_i <= a;
        write_i <= wr;
        read_i <= !wr;
        if (wr) writedata_i <= d;
        else begin
            exp_q.push_back(d);
            tol_q.push_back(tol);
        end
        // no wait limit here: only the watchdog may end a stuck access
        do begin
            @(posedge clk_i);
        end while (waitrequest_o !== 1'b0);
        write_i <= 1'b0;
        read_i <= 1'b0;
    endtask
    task automatic wr(logic [4:0] a, logic [31:0] d);
        bus(1'b1, a, d, 32'h0);
    endtask
    task automatic rd(logic [4:0] a, logic [31:0] e, logic [31:0] tol);
        bus(1'b0, a, e, tol);
    endtask
    task automatic wait_n(int n);
        repeat (n) @(posedge clk_i);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ======
    // monitor: pulse times, read data against the oldest note
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (sample_valid_o[0] === 1'b1) begin
            p0 <= t0;
            t0 <= cyc;
        end
        if (sample_valid_o[1] === 1'b1) t1 <= cyc;
        if (read_i && waitrequest_o === 1'b0) begin
            checks_done++;
            if (!near(readdata_o, exp_q[0], tol_q[0])) begin
                mismatches++;
                $display("MISMATCH t=%0t addr %h got %h want %h", $time,
                    address_i, readdata_o, exp_q[0]);
            end
            void'(exp_q.pop_front());
            void'(tol_q.pop_front());
        end
    end
    initial begin
        wait_n(40000);
        mismatches++;
        $display("MISMATCH t=%0t run too long", $time);
        give_verdict();
    end
    // ======
    // main sequence
    initial begin
        void'($urandom(79270));
        wait_n(20);
        rst_i <= 1'b0;
        rd(5'h00, 32'h4, 0);
        rd(5'h04, 32'h0, 0);
        rd(5'h08, 32'h0, 0);
        wr(5'h1c, 32'hffffffff);
        rd(5'h1c, 32'h0, 0);
        wr(5'h00, 32'hf);
        rd(5'h00, 32'h8, 0);
        wr(5'h0c, 32'h1c05);
        rd(5'h0c, 32'h1c05, 0);
        $display("test registers done");
        wr(5'h00, 32'h0);
        for (int i = 0; i < 7; i++) begin
            ph = i < 5 ? phs[i] : 10'($urandom);
            wr(5'h0c, {22'h0, ph});
            wait_n(320);
            check(t0 - p0, 64);
            check(((t1 - t0) % 64 + 64) % 64, shift64(ph));
        end
        wr(5'h0c, 32'h0);
        wr(5'h00, 32'h5);
        wait_n(10240);
        check(t0 - p0, 2048);
        check(t1 - t0, 0);
        wr(5'h00, 32'h0);
        $display("test phase done");
        noisy <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            wr(5'h08, 32'(s0[i]) << 10);
            wr(5'h0c, 32'(s1[i]) << 10);
            wait_n(400);
            rd(5'h10, full(pick(s0[i], lvl[0])), 0);
            rd(5'h14, full(pick(s1[i], lvl[1])), 0);
        end
        $display("test input select done");
        lvl <= 2'h3;
        wr(5'h08, 32'h0);
        wr(5'h0c, 32'h1000);
        wr(5'h04, 32'h1);
        wait_n(7680);
        rd(5'h10, 32'h0, 32'h100);
        rd(5'h14, full(1), 0);
        wr(5'h04, 32'h0);
        wait_n(400);
        rd(5'h10, full(1), 0);
        wr(5'h04, 32'hf);
        wait_n(512);
        rd(5'h10, full(1), 32'h1000);
        for (int n = 0; n < 200 && sample_valid_o[0] !== 1'b1; n++)
            @(posedge clk_i);
        rd(5'h18, 32'h3, 0);
        rd(5'h10, full(1), 32'h1000);
        rd(5'h18, 32'h2, 0);
        $display("test high-pass done");
        give_verdict();
    end
endmodule
`default_nettype wire
